// ---- hdl/byte_dma_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dma_regs.svh"
module byte_dma_ctrl
  import dma_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             mem_cyc_o,
  output logic             mem_stb_o,
  output logic             mem_we_o,
  output logic      [23:0] mem_adr_o,
  output logic      [3:0]  mem_sel_o,
  output logic      [31:0] mem_dat_o,
  input  wire logic [31:0] mem_dat_i,
  input  wire logic        mem_ack_i,
  output logic             cpu_hold_o,
  input  wire logic [2:0]  channel_request_in_i,
  input  wire logic [1:0]  port_irq_i,
  input  wire logic [7:0]  pixel_bus_data_reg_i,
  input  wire logic [7:0]  serial0_data_reg_i,
  input  wire logic [7:0]  serial1_data_reg_i,
  output logic      [7:0]  periph_wdata_o,
  output logic      [2:0]  periph_wr_o,
  output logic      [2:0]  transfer_ack_o,
  output logic      [2:0]  sequence_done_irq_o,
  output logic             pixel_bus_seq_end_o
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic [16:0]              vbase_reg, vbase_next;
  logic                     de_reg, de_next;
  logic [NUM_CH-1:0][1:0]   sel_reg, sel_next;
  logic [NUM_CH-1:0][7:0]   dmat_reg, dmat_next;
  logic [NUM_CH-1:0]        dir_reg, dir_next, byp_reg, byp_next, en_reg, en_next;
  logic [31:0]              rdat_reg, rdat_next;
  logic                     wack_reg, wack_next;
  logic [NUM_CH-1:0]        sw_clr, pend, byp_irq, tick, active;
  logic [NUM_CH-1:0][31:0]  chw;
  logic [31:0]              tmp;
  logic                     wr, rd;
  logic [1:0]               pirq_s1, pirq_s2, src;

  dma_state_t               state_reg, state_next;
  logic [1:0]               ch_reg, ch_next;
  logic [23:0]              vaddr_reg, vaddr_next, vec_adr;
  logic [7:0]               vcnt_reg, vcnt_next, pbyte, wdata_reg, wdata_next;
  logic                     mcyc_reg, mcyc_next, mwe_reg, mwe_next;
  logic [23:0]              madr_reg, madr_next;
  logic [3:0]               msel_reg, msel_next;
  logic [31:0]              mdat_reg, mdat_next;
  logic [NUM_CH-1:0]        ack_reg, ack_next, done_reg, done_next, pwr_reg, pwr_next;
  logic [NUM_CH-1:0]        end_clr, pend_clr, ch_oh;
  logic                     pix_reg;

  for (genvar k = 0; k < NUM_CH; k++)
  begin : g_ch
    dma_timer #(.DIV_W(DIV_W)) u_timer (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (de_reg),
      .exp_i  (dmat_reg[k]),
      .tick_o (tick[k])
    );
    dma_channel u_chan (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .module_req_i (channel_request_in_i[k]),
      .timer_tick_i (tick[k]),
      .port_irq_i   (pirq_s2),
      .src_sel_i    (sel_reg[k]),
      .bypass_i     (byp_reg[k]),
      .done_clr_i   (pend_clr[k]),
      .sw_clr_i     (sw_clr[k]),
      .pending_o    (pend[k]),
      .bypass_irq_o (byp_irq[k])
    );
  end

  always_comb
  begin
    active = pend & en_reg & {NUM_CH{de_reg}};
    // Higher priority number wins; 0 means no channel is selected.
    if (active[2])      src = 2'h3;
    else if (active[1]) src = 2'h2;
    else if (active[0]) src = 2'h1;
    else                src = 2'h0;
    for (int k = 0; k < NUM_CH; k++)
    begin
      chw[k] = {15'h0000, pend[k], dmat_reg[k], en_reg[k], 3'h0, byp_reg[k], dir_reg[k],
                sel_reg[k]};
    end
  end

  always_comb
  begin
    tmp        = 32'h0000_0000;
    wr         = wb_cyc_i && wb_stb_i && wb_we_i && !wack_reg;
    rd         = wb_cyc_i && wb_stb_i && !wb_we_i && !wack_reg;
    wack_next  = wb_cyc_i && wb_stb_i && !wack_reg;
    rdat_next  = 32'h0000_0000;
    vbase_next = vbase_reg;
    de_next    = de_reg;
    sel_next   = sel_reg;
    dmat_next  = dmat_reg;
    dir_next   = dir_reg;
    byp_next   = byp_reg;
    en_next    = en_reg & ~end_clr;
    sw_clr     = '0;
    if (wb_adr_i == `DMA_VBASE_OFS)
    begin
      tmp = merge({8'h00, vbase_reg, 7'h00}, wb_dat_i, wb_sel_i);
      if (wr) vbase_next = tmp[`DMA_VBASE_MSB:`DMA_VBASE_LSB];
      if (rd) rdat_next = {8'h00, vbase_reg, 7'h00};
    end
    if (wb_adr_i == `DMA_STATUS_OFS)
    begin
      tmp = merge({24'h000000, de_reg, 7'h00}, wb_dat_i, wb_sel_i);
      if (wr) de_next = tmp[`DMA_DE_BIT];
      if (rd) rdat_next = {24'h000000, de_reg, 5'h00, src};
    end
    for (int k = 0; k < NUM_CH; k++)
    begin
      if (wb_adr_i == `DMA_CHMODE_OFS + 8'(k) * `DMA_CHMODE_STEP)
      begin
        tmp = merge(chw[k], wb_dat_i, wb_sel_i);
        if (wr)
        begin
          sel_next[k]  = tmp[`DMA_SEL_MSB:0];
          dir_next[k]  = tmp[`DMA_DIR_BIT];
          byp_next[k]  = tmp[`DMA_BYP_BIT];
          en_next[k]   = tmp[`DMA_EN_BIT];
          dmat_next[k] = tmp[`DMA_DMAT_MSB:`DMA_DMAT_LSB];
          sw_clr[k]    = wb_sel_i[`DMA_P_LANE] && !wb_dat_i[`DMA_P_BIT];
        end
        if (rd) rdat_next = chw[k];
      end
    end
  end

  always_comb
  begin
    state_next = state_reg;
    ch_next    = ch_reg;
    vaddr_next = vaddr_reg;
    vcnt_next  = vcnt_reg;
    mcyc_next  = mcyc_reg;
    mwe_next   = mwe_reg;
    madr_next  = madr_reg;
    msel_next  = msel_reg;
    mdat_next  = mdat_reg;
    wdata_next = wdata_reg;
    ack_next   = '0;
    pwr_next   = '0;
    end_clr    = '0;
    pend_clr   = '0;
    done_next  = byp_irq;
    ch_oh      = 3'b001 << ch_reg;
    vec_adr    = {vbase_reg, 7'h00} + {20'h00000, ch_reg + 2'h1, 2'b00};
    case (ch_reg)
      2'h0:    pbyte = pixel_bus_data_reg_i;
      2'h1:    pbyte = serial0_data_reg_i;
      default: pbyte = serial1_data_reg_i;
    endcase
    // Each access is issued after one idle bus cycle and held until acknowledged.
    case (state_reg)
      ST_IDLE:
        if (src != 2'h0)
        begin
          ch_next    = src - 2'h1;
          state_next = ST_VEC_RD;
        end
      ST_VEC_RD:
        if (!mcyc_reg)
        begin
          mcyc_next = 1'b1;
          mwe_next  = 1'b0;
          madr_next = vec_adr;
          msel_next = `DMA_SEL_ALL;
        end
        else if (mem_ack_i)
        begin
          mcyc_next  = 1'b0;
          vaddr_next = mem_dat_i[`DMA_VEC_ADR_MSB:0];
          vcnt_next  = mem_dat_i[`DMA_VEC_CNT_MSB:`DMA_VEC_CNT_LSB];
          state_next = ST_VEC_WR;
        end
      ST_VEC_WR:
        if (!mcyc_reg)
        begin
          mcyc_next = 1'b1;
          mwe_next  = 1'b1;
          madr_next = vec_adr;
          mdat_next = {vcnt_reg - 8'h01, vaddr_reg + 24'h000001};
        end
        else if (mem_ack_i)
        begin
          mcyc_next  = 1'b0;
          state_next = ST_XFER;
        end
      ST_XFER:
        if (!mcyc_reg)
        begin
          mcyc_next = 1'b1;
          mwe_next  = !dir_reg[ch_reg];
          madr_next = vaddr_reg;
          msel_next = 4'h1 << vaddr_reg[1:0];
          mdat_next = {4{pbyte}};
        end
        else if (mem_ack_i)
        begin
          mcyc_next  = 1'b0;
          wdata_next = mem_dat_i[8*madr_reg[1:0] +: 8];
          pwr_next   = dir_reg[ch_reg] ? ch_oh : '0;
          ack_next   = ch_oh;
          pend_clr   = ch_oh;
          if (vcnt_reg == `DMA_CNT_LAST)
          begin
            end_clr   = ch_oh;
            done_next = byp_irq | ch_oh;
          end
          state_next = ST_IDLE;
        end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vbase_reg <= '0;
      de_reg    <= 1'b0;
      sel_reg   <= '0;
      dmat_reg  <= '0;
      dir_reg   <= '0;
      byp_reg   <= '0;
      en_reg    <= '0;
      rdat_reg  <= '0;
      wack_reg  <= 1'b0;
      pirq_s1   <= '0;
      pirq_s2   <= '0;
      state_reg <= ST_IDLE;
      ch_reg    <= '0;
      vaddr_reg <= '0;
      vcnt_reg  <= '0;
      mcyc_reg  <= 1'b0;
      mwe_reg   <= 1'b0;
      madr_reg  <= '0;
      msel_reg  <= '0;
      mdat_reg  <= '0;
      wdata_reg <= '0;
      ack_reg   <= '0;
      pwr_reg   <= '0;
      done_reg  <= '0;
      pix_reg   <= 1'b0;
    end
    else
    begin
      vbase_reg <= vbase_next;
      de_reg    <= de_next;
      sel_reg   <= sel_next;
      dmat_reg  <= dmat_next;
      dir_reg   <= dir_next;
      byp_reg   <= byp_next;
      en_reg    <= en_next;
      rdat_reg  <= rdat_next;
      wack_reg  <= wack_next;
      pirq_s1   <= port_irq_i;
      pirq_s2   <= pirq_s1;
      state_reg <= state_next;
      ch_reg    <= ch_next;
      vaddr_reg <= vaddr_next;
      vcnt_reg  <= vcnt_next;
      mcyc_reg  <= mcyc_next;
      mwe_reg   <= mwe_next;
      madr_reg  <= madr_next;
      msel_reg  <= msel_next;
      mdat_reg  <= mdat_next;
      wdata_reg <= wdata_next;
      ack_reg   <= ack_next;
      pwr_reg   <= pwr_next;
      done_reg  <= done_next;
      pix_reg   <= done_next[0];
    end
  end

  assign wb_dat_o            = rdat_reg;
  assign wb_ack_o            = wack_reg;
  assign mem_cyc_o           = mcyc_reg;
  assign mem_stb_o           = mcyc_reg;
  assign cpu_hold_o          = mcyc_reg;
  assign mem_we_o            = mwe_reg;
  assign mem_adr_o           = madr_reg;
  assign mem_sel_o           = msel_reg;
  assign mem_dat_o           = mdat_reg;
  assign periph_wdata_o      = wdata_reg;
  assign periph_wr_o         = pwr_reg;
  assign transfer_ack_o      = ack_reg;
  assign sequence_done_irq_o = done_reg;
  assign pixel_bus_seq_end_o = pix_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd_done;
    state_reg == ST_VEC_RD && mem_cyc_o && mem_ack_i;
  endsequence
  sequence s_gap_then_wr;
    !mem_cyc_o ##1 (mem_cyc_o && mem_we_o && mem_adr_o == $past(mem_adr_o, 2));
  endsequence

  AST_VEC_RD_ADDR: assert property (
    state_reg == ST_VEC_RD && mem_cyc_o |-> !mem_we_o && mem_adr_o == vec_adr
  ) else $error("descriptor read at wrong address");
  AST_RD_THEN_WR: assert property (s_rd_done |=> s_gap_then_wr)
    else $error("write-back did not follow descriptor read");
  AST_WB_DATA: assert property (
    state_reg == ST_VEC_WR && mem_cyc_o |->
      mem_dat_o == {vcnt_reg - 8'h01, vaddr_reg + 24'h000001}
  ) else $error("wrong write-back data");
  AST_XFER_ADDR: assert property (
    state_reg == ST_XFER && mem_cyc_o |-> mem_adr_o == vaddr_reg
  ) else $error("data access at wrong address");
  AST_REQ_HOLD: assert property (
    mem_cyc_o && !mem_ack_i |=> mem_cyc_o && $stable(mem_adr_o) && $stable(mem_we_o)
  ) else $error("bus request dropped or changed before ack");
  AST_ACK_CAUSE: assert property (
    transfer_ack_o != 3'h0 |-> $past(state_reg == ST_XFER && mem_cyc_o && mem_ack_i)
  ) else $error("acknowledge without finished transfer");
  // Checked at the deciding cycle, since the previous channel number is still held then.
  AST_WIN_ENABLED: assert property (
    state_reg == ST_IDLE && state_next == ST_VEC_RD |->
      en_reg[ch_next] && pend[ch_next] && de_reg
  ) else $error("disabled or idle channel won arbitration");
  AST_END_SEQ: assert property (
    state_reg == ST_XFER && mem_cyc_o && mem_ack_i && vcnt_reg == `DMA_CNT_LAST &&
      !wr |=> sequence_done_irq_o == ($past(ch_oh) | $past(byp_irq)) && !en_reg[$past(ch_reg)]
  ) else $error("sequence end not signalled");
  AST_PIXEL_FLAG: assert property (
    pixel_bus_seq_end_o == sequence_done_irq_o[0]
  ) else $error("pixel bus end flag disagrees with done interrupt");
  AST_PRIORITY: assert property (
    active[2] |-> src == 2'h3
  ) else $error("highest channel not selected");

endmodule // byte_dma_ctrl
`default_nettype wire

// ---- hdl/dma_regs.svh ----
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH

`define DMA_VBASE_OFS    8'h00
`define DMA_STATUS_OFS   8'h04
`define DMA_CHMODE_OFS   8'h08
`define DMA_CHMODE_STEP  8'h04

`define DMA_VBASE_LSB    7
`define DMA_VBASE_MSB    23
`define DMA_DE_BIT       7
`define DMA_SRC_MSB      1
`define DMA_SEL_MSB      1
`define DMA_DIR_BIT      2
`define DMA_BYP_BIT      3
`define DMA_EN_BIT       7
`define DMA_DMAT_LSB     8
`define DMA_DMAT_MSB     15
`define DMA_P_BIT        16
`define DMA_P_LANE       2

`define DMA_VEC_ADR_MSB  23
`define DMA_VEC_CNT_LSB  24
`define DMA_VEC_CNT_MSB  31
`define DMA_CNT_LAST     8'h01
`define DMA_SEL_ALL      4'hf

`define DMA_SRC_MODULE   2'h0
`define DMA_SRC_TIMER    2'h1
`define DMA_SRC_PORT0    2'h2
`define DMA_SRC_PORT1    2'h3

`endif

// ---- hdl/dma_pkg.sv ----
package dma_pkg;

  localparam int NUM_CH = 3;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_VEC_RD = 2'b01,
    ST_VEC_WR = 2'b11,
    ST_XFER   = 2'b10
  } dma_state_t;

endpackage

// ---- hdl/dma_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module dma_timer
#(
  parameter int DIV_W = 16
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [7:0] exp_i,
  output logic            tick_o
);

  if (DIV_W < 2 || DIV_W > 24)
  begin : g_chk
    $error("dma_timer: DIV_W out of range");
  end

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic [DIV_W-1:0] mask;
  logic             tick_reg;
  logic             tick_next;

  // Exponents beyond the counter width saturate to the slowest rate.
  always_comb
  begin
    mask = '0;
    for (int i = 0; i < DIV_W; i++)
    begin
      if (i <= int'(exp_i))
      begin
        mask[i] = 1'b1;
      end
    end
    cnt_next  = run_i ? cnt_reg + 1'b1 : '0;
    tick_next = run_i && ((cnt_reg & mask) == mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule // dma_timer
`default_nettype wire

// ---- hdl/dma_channel.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dma_regs.svh"
module dma_channel
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       module_req_i,
  input  wire logic       timer_tick_i,
  input  wire logic [1:0] port_irq_i,
  input  wire logic [1:0] src_sel_i,
  input  wire logic       bypass_i,
  input  wire logic       done_clr_i,
  input  wire logic       sw_clr_i,
  output logic            pending_o,
  output logic            bypass_irq_o
);

  logic req_sel;
  logic prev_reg;
  logic pend_reg;
  logic pend_next;
  logic birq_reg;
  logic birq_next;
  logic rise;

  always_comb
  begin
    case (src_sel_i)
      `DMA_SRC_MODULE: req_sel = module_req_i;
      `DMA_SRC_TIMER:  req_sel = timer_tick_i;
      `DMA_SRC_PORT0:  req_sel = port_irq_i[0];
      `DMA_SRC_PORT1:  req_sel = port_irq_i[1];
      default:         req_sel = 1'b0;
    endcase
    rise = req_sel && !prev_reg;
    // A new request beats a clear in the same cycle, so no request is lost.
    pend_next = (rise && !bypass_i) || (pend_reg && !done_clr_i && !sw_clr_i);
    birq_next = rise && bypass_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_reg <= 1'b0;
      pend_reg <= 1'b0;
      birq_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= req_sel;
      pend_reg <= pend_next;
      birq_reg <= birq_next;
    end
  end

  assign pending_o    = pend_reg;
  assign bypass_irq_o = birq_reg;

endmodule // dma_channel
`default_nettype wire

// ---- sim/dma_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dma_mem_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [23:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  lat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o
);
  logic [31:0] mem [0:63];
  logic [3:0]  wait_reg;
  logic [31:0] last_reg;

  // Outside an acknowledge the bus shows the inverse of the last word, so a late sample fails.
  assign dat_o = ack_o ? last_reg : ~last_reg;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      wait_reg <= 4'h0;
      last_reg <= 32'h0;
    end
    else if (cyc_i && stb_i && !ack_o)
    begin
      if (wait_reg == lat_i)
      begin
        ack_o <= 1'b1;
        wait_reg <= 4'h0;
        last_reg <= mem[adr_i[7:2]];
        for (int b = 0; b < 4; b++)
          if (we_i && sel_i[b])
            mem[adr_i[7:2]][8*b +: 8] <= dat_i[8*b +: 8];
      end
      else
        wait_reg <= wait_reg + 4'h1;
    end
    else
      ack_o <= 1'b0;
  end
endmodule // dma_mem_model
`default_nettype wire

// ---- sim/byte_dma_cycle_steal_controller_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module byte_dma_cycle_steal_controller_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0, lat = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, mem_dat_o, mem_dat_i, rdata;
  logic        wb_ack_o, mem_cyc_o, mem_stb_o, mem_we_o, mem_ack_i, cpu_hold_o, end_o, cyc_q;
  logic [23:0] mem_adr_o;
  logic [3:0]  mem_sel_o;
  logic [2:0]  req = 3'h0, periph_wr_o, transfer_ack_o, done_o;
  logic [1:0]  port_irq = 2'h0;
  logic [7:0]  ser0 = 8'h00, periph_wdata_o, last_wdata;
  int          n_fail = 0, samples_checked = 0, steal_cnt = 0, end_cnt = 0;
  int          ack_cnt [3] = '{0, 0, 0};
  int          done_cnt [3] = '{0, 0, 0};
  int          wr_cnt [3] = '{0, 0, 0};

  always #2.5 clk_i = ~clk_i;

  byte_dma_ctrl #(.DIV_W(4)) byte_dma_ctrl_i
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_stb_o(mem_stb_o), .mem_we_o(mem_we_o),
    .mem_adr_o(mem_adr_o), .mem_sel_o(mem_sel_o), .mem_dat_o(mem_dat_o),
    .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i), .cpu_hold_o(cpu_hold_o),
    .channel_request_in_i(req), .port_irq_i(port_irq), .pixel_bus_data_reg_i(8'h00),
    .serial0_data_reg_i(ser0), .serial1_data_reg_i(8'h00), .periph_wdata_o(periph_wdata_o),
    .periph_wr_o(periph_wr_o), .transfer_ack_o(transfer_ack_o),
    .sequence_done_irq_o(done_o), .pixel_bus_seq_end_o(end_o)
  );

  dma_mem_model dma_mem_model_i
  (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(mem_cyc_o), .stb_i(mem_stb_o), .we_i(mem_we_o),
    .adr_i(mem_adr_o), .sel_i(mem_sel_o), .dat_i(mem_dat_o), .lat_i(lat),
    .dat_o(mem_dat_i), .ack_o(mem_ack_i)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("counts: checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A bus cycle holds every request signal until ack is sampled high at a rising edge.
  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1)
    begin
      n_fail++;
      conclude();
    end
    rdata = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_io(1'b0, adr, 32'h0);
    check(rdata, exp);
  endtask

  task automatic pulse(input logic [2:0] m);
    req <= m;
    @(posedge clk_i);
    req <= 3'h0;
    @(posedge clk_i);
  endtask

  task automatic wait_for(input bit done, input int ch, input int target);
    int n;
    n = 0;
    while ((done ? done_cnt[ch] : ack_cnt[ch]) < target && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if ((done ? done_cnt[ch] : ack_cnt[ch]) < target)
    begin
      n_fail++;
      conclude();
    end
  endtask

  always @(posedge clk_i)
  begin
    cyc_q <= mem_cyc_o;
    if (mem_cyc_o === 1'b1 && cyc_q !== 1'b1)
      steal_cnt++;
    if (end_o === 1'b1)
      end_cnt++;
    for (int c = 0; c < 3; c++)
    begin
      if (transfer_ack_o[c] === 1'b1)
        ack_cnt[c]++;
      if (done_o[c] === 1'b1)
        done_cnt[c]++;
      if (periph_wr_o[c] === 1'b1)
      begin
        wr_cnt[c]++;
        last_wdata = periph_wdata_o;
      end
    end
    if (!rst_i)
    begin
      check({30'h0, end_o, cpu_hold_o}, {30'h0, done_o[0], mem_cyc_o});
    end
  end

  initial
  begin
    for (int i = 0; i < 64; i++)
      dma_mem_model_i.mem[i] = 32'h0;
    dma_mem_model_i.mem[33] = {8'h02, 24'h000020};
    dma_mem_model_i.mem[8] = 32'h00003ca5;
    dma_mem_model_i.mem[34] = {8'h01, 24'h000031};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a <= 16; a += 4)
      rd_chk(8'(a), 32'h0);
    rd_chk(8'hfc, 32'h0);
    wb_io(1'b1, 8'h00, 32'hffffffff);
    rd_chk(8'h00, 32'h00ffff80);
    wb_io(1'b1, 8'h00, 32'h00000080);
    $display("test registers done");
    wb_io(1'b1, 8'h04, 32'h00000080);
    wb_io(1'b1, 8'h08, 32'h00000084);
    pulse(3'h1);
    wait_for(1'b0, 0, 1);
    check(steal_cnt, 3);
    check({24'h000000, last_wdata}, 32'h000000a5);
    check(dma_mem_model_i.mem[33], {8'h01, 24'h000021});
    check(done_cnt[0], 0);
    lat <= 4'h3;
    pulse(3'h1);
    wait_for(1'b0, 0, 2);
    check({24'h000000, last_wdata}, 32'h0000003c);
    check(dma_mem_model_i.mem[33], {8'h00, 24'h000022});
    check({8'(done_cnt[0]), 8'(end_cnt), 8'(wr_cnt[0]), 8'(steal_cnt)}, 32'h01010206);
    check(dma_mem_model_i.mem[8], 32'h00003ca5);
    rd_chk(8'h08, 32'h00000004);
    $display("test pixel write sequence done");
    ser0 <= 8'h5e;
    wb_io(1'b1, 8'h0c, 32'h00000080);
    pulse(3'h2);
    wait_for(1'b0, 1, 1);
    check(dma_mem_model_i.mem[12], 32'h00005e00);
    check({16'(wr_cnt[1]), 16'(done_cnt[1])}, 32'h00000001);
    check(dma_mem_model_i.mem[34], {8'h00, 24'h000032});
    $display("test serial read done");
    wb_io(1'b1, 8'h10, 32'h00000008);
    lat <= 4'h0;
    begin
      int s;
      s = steal_cnt;
      pulse(3'h4);
      wait_for(1'b1, 2, 1);
      repeat (4) @(posedge clk_i);
      check(steal_cnt, s);
    end
    rd_chk(8'h10, 32'h00000008);
    $display("test reroute done");
    wb_io(1'b1, 8'h04, 32'h0);
    wb_io(1'b1, 8'h0c, 32'h00000080);
    wb_io(1'b1, 8'h10, 32'h00000080);
    pulse(3'h6);
    repeat (3) @(posedge clk_i);
    // With the controller off nothing is selected, even with both channels pending.
    rd_chk(8'h04, 32'h0);
    wb_io(1'b1, 8'h04, 32'h00000080);
    rd_chk(8'h04, 32'h00000083);
    wb_io(1'b1, 8'h10, 32'h0);
    rd_chk(8'h04, 32'h00000082);
    wb_io(1'b1, 8'h0c, 32'h0);
    rd_chk(8'h04, 32'h00000080);
    $display("test priority done");
    wb_io(1'b1, 8'h04, 32'h00000080);
    for (int s = 1; s < 4; s++)
    begin
      wb_io(1'b1, 8'h08, 32'h00000100 | 32'(s));
      if (s > 1)
        port_irq[s-2] <= 1'b1;
      repeat (12) @(posedge clk_i);
      rd_chk(8'h08, 32'h00010100 | 32'(s));
      // Park the source first, so that a late timer edge cannot beat the clear.
      wb_io(1'b1, 8'h08, 32'h00010000);
      port_irq <= 2'h0;
      wb_io(1'b1, 8'h08, 32'h0);
      rd_chk(8'h08, 32'h0);
    end
    $display("test request sources done");
    conclude();
  end
endmodule // byte_dma_cycle_steal_controller_tb
`default_nettype wire
